// ### hdl/tm_monitor.sv
// Temperature monitor control: bus slave, conversion sequencer, alert
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Writing configuration bit 6 to one puts the block into standby.
// - With bit 6 zero, both channels convert continuously.
// - Entering standby aborts a running conversion; its result is dropped.
// - The serial bus slave keeps working in standby.
// - In standby, any write to address 0fh converts both channels once.
// - Each conversion start samples the open comparator into status bit 2.
// - Remote input below range reads as -128, code 80h.
// - Low limits reset to -55, so a shorted sensor raises the alert.
// - Alert pin is driven low on any limit breach or open sensor.
// - After alert response, alert releases only if its cause has gone.
module tm_monitor
  import tm_pkg::*;
#(
  parameter logic [6:0]  DEV_ADDR   = DEV_DFLT,
  parameter int unsigned GAP_CYCLES = CONV_GAP_CYC
) (
  // Clock, reset, enable
  input  wire logic       i_mclk,
  input  wire logic       i_reset_n,
  input  wire logic       i_ce,
  // Serial management bus
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_out,
  output logic            o_sda_oe,
  // Alert pin, open drain
  output logic            o_alert_out,
  output logic            o_alert_oe,
  // Converter
  output logic            o_adc_en,
  output logic            o_conv_start,
  output logic            o_conv_chan,
  input  wire logic       i_conv_done,
  input  wire logic [7:0] i_conv_data,
  input  wire logic       i_conv_under,
  input  wire logic       i_open_fault,
  // State
  output logic            o_standby
);
  generate
    if (GAP_CYCLES < 1) begin : g_bad_gap
      $error("GAP_CYCLES must be at least one");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pin synchronisers and bus edge detect
  // ----------------------------------------------------------------
  logic [2:0] sync;
  logic       scl_q;
  logic       sda_q;

  // Open flag inverted: synchroniser reset level then means no fault
  tm_sync #(.W(3)) u_sync (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_ce      (i_ce),
    .i_async   ({~i_open_fault, i_sda, i_scl}),
    .o_sync    (sync)
  );

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (i_ce) begin
      scl_q <= sync[0];
      sda_q <= sync[1];
    end
  end

  wire scl_rise = sync[0] & ~scl_q;
  wire scl_fall = ~sync[0] & scl_q;
  wire bus_start = sync[0] & scl_q & sda_q & ~sync[1];
  wire bus_stop  = sync[0] & scl_q & ~sda_q & sync[1];

  // ----------------------------------------------------------------
  // Registers and helpers
  // ----------------------------------------------------------------
  logic [7:0] cfg, lhigh, llow, rhigh, rlow, ltemp, rtemp;
  logic [3:0] sts_lim;
  logic       sts_open;
  logic       shot_pend;
  logic       wr_en;
  logic       ara_done;
  logic [7:0] ptr, sh;
  wire  [7:0] status = {1'b0, sts_lim, sts_open, 2'b00};

  function automatic logic above(input logic [7:0] v, input logic [7:0] l);
    above = $signed(v) > $signed(l);
  endfunction : above

  function automatic logic below(input logic [7:0] v, input logic [7:0] l);
    below = $signed(v) < $signed(l);
  endfunction : below

  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    case (a)
      A_LOCAL:  rd_mux = ltemp;
      A_REMOTE: rd_mux = rtemp;
      A_STATUS: rd_mux = status;
      A_CONFIG: rd_mux = cfg;
      A_LHIGH:  rd_mux = lhigh;
      A_LLOW:   rd_mux = llow;
      A_RHIGH:  rd_mux = rhigh;
      A_RLOW:   rd_mux = rlow;
      default:  rd_mux = 8'h00;
    endcase
  endfunction : rd_mux

  // ----------------------------------------------------------------
  // Serial bus slave
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    B_IDLE, B_ADDR, B_ACK, B_WDATA, B_RDATA, B_RACK
  } tm_bus_t;

  tm_bus_t    bstate;
  logic [3:0] bitcnt;
  logic [7:0] tx;
  logic       rw, ara, first, rack_ok;
  wire  [7:0] next_tx = ara ? {DEV_ADDR, 1'b0} : rd_mux(ptr);

  // Runs regardless of standby
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bstate   <= B_IDLE;
      bitcnt   <= 4'h0;
      sh       <= 8'h00;
      tx       <= 8'h00;
      ptr      <= 8'h00;
      rw       <= 1'b0;
      ara      <= 1'b0;
      first    <= 1'b0;
      rack_ok  <= 1'b0;
      o_sda_oe <= 1'b0;
      wr_en    <= 1'b0;
      ara_done <= 1'b0;
    end else if (i_ce) begin
      wr_en    <= 1'b0;
      ara_done <= 1'b0;
      if (bus_start) begin
        bstate   <= B_ADDR;
        bitcnt   <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (bus_stop) begin
        bstate   <= B_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        case (bstate)
          B_ADDR, B_WDATA: begin
            if (scl_rise && bitcnt != BYTE_BITS) begin
              sh     <= {sh[6:0], sync[1]};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == BYTE_BITS) begin
              if (bstate == B_WDATA) begin
                o_sda_oe <= 1'b1;
                first    <= 1'b0;
                bstate   <= B_ACK;
                if (first) ptr <= sh;
                else wr_en <= 1'b1;
              end else if (sh[7:1] == DEV_ADDR) begin
                o_sda_oe <= 1'b1;
                rw       <= sh[0];
                ara      <= 1'b0;
                first    <= 1'b1;
                bstate   <= B_ACK;
              end else if (sh[7:1] == ARA_ADDR && sh[0] && o_alert_oe) begin
                o_sda_oe <= 1'b1;
                rw       <= 1'b1;
                ara      <= 1'b1;
                bstate   <= B_ACK;
              end else begin
                bstate <= B_IDLE;
              end
            end
          end
          B_ACK: begin
            if (scl_fall) begin
              bitcnt <= 4'h0;
              if (rw) begin
                tx       <= next_tx;
                o_sda_oe <= ~next_tx[7];
                bstate   <= B_RDATA;
              end else begin
                o_sda_oe <= 1'b0;
                bstate   <= B_WDATA;
              end
            end
          end
          B_RDATA: begin
            if (scl_fall) begin
              if (bitcnt == LAST_BIT) begin
                o_sda_oe <= 1'b0;
                bstate   <= B_RACK;
              end else begin
                tx       <= {tx[6:0], 1'b0};
                o_sda_oe <= ~tx[6];
                bitcnt   <= bitcnt + 4'h1;
              end
            end
          end
          B_RACK: begin
            if (scl_rise) begin
              rack_ok  <= ~sync[1];
              ara_done <= ara;
            end else if (scl_fall) begin
              if (rack_ok && !ara) begin
                tx       <= next_tx;
                o_sda_oe <= ~next_tx[7];
                bitcnt   <= 4'h0;
                bstate   <= B_RDATA;
              end else begin
                bstate <= B_IDLE;
              end
            end
          end
          default: bstate <= B_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Host-written registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg    <= RST_CONFIG;
      lhigh  <= RST_HIGH;
      llow   <= RST_LOW;
      rhigh  <= RST_HIGH;
      rlow   <= RST_LOW;
    end else if (i_ce) begin
      if (wr_en) begin
        case (ptr)
          A_CONFIG: cfg   <= sh;
          A_LHIGH:  lhigh <= sh;
          A_LLOW:   llow  <= sh;
          A_RHIGH:  rhigh <= sh;
          A_RLOW:   rlow  <= sh;
          default:  ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {C_IDLE, C_START, C_WAIT, C_GAP} tm_conv_t;

  tm_conv_t    cstate;
  logic        single;
  logic [31:0] gap_cnt;
  wire shot_set = wr_en && ptr == A_ONESHOT && cfg[CFG_STBY];
  wire shot_take = cstate == C_IDLE && shot_pend;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      shot_pend <= 1'b0;
    end else if (i_ce) begin
      shot_pend <= shot_set | (shot_pend & ~shot_take);
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cstate       <= C_IDLE;
      single       <= 1'b0;
      gap_cnt      <= 32'h0;
      o_conv_start <= 1'b0;
      o_conv_chan  <= 1'b0;
      o_adc_en     <= 1'b0;
      ltemp        <= RST_TEMP;
      rtemp        <= RST_TEMP;
      sts_open     <= 1'b0;
    end else if (i_ce) begin
      o_conv_start <= 1'b0;
      o_adc_en <= ~cfg[CFG_STBY] | single;
      case (cstate)
        C_IDLE: begin
          if (!cfg[CFG_STBY] || shot_pend) begin
            cstate      <= C_START;
            o_conv_chan <= 1'b0;
            single      <= cfg[CFG_STBY];
          end else begin
            single <= 1'b0;
          end
        end
        C_START: begin
          o_conv_start <= 1'b1;
          sts_open     <= ~sync[2];
          cstate       <= C_WAIT;
        end
        C_WAIT: begin
          // Standby level, so a start already launched is dropped too
          if (cfg[CFG_STBY] && !single) begin
            cstate <= C_IDLE;
          end else if (i_conv_done) begin
            if (!o_conv_chan) begin
              ltemp       <= i_conv_data;
              o_conv_chan <= 1'b1;
              cstate      <= C_START;
            end else begin
              rtemp   <= i_conv_under ? SHORT_CODE : i_conv_data;
              gap_cnt <= 32'h0;
              cstate  <= (single || cfg[CFG_STBY]) ? C_IDLE : C_GAP;
            end
          end
        end
        C_GAP: begin
          if (cfg[CFG_STBY] || gap_cnt == 32'(GAP_CYCLES - 1)) begin
            cstate <= C_IDLE;
          end else begin
            gap_cnt <= gap_cnt + 32'h1;
          end
        end
        default: cstate <= C_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Limit status and alert
  // ----------------------------------------------------------------
  wire cond = |sts_lim | sts_open;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sts_lim    <= 4'h0;
      o_alert_oe <= 1'b0;
    end else if (i_ce) begin
      sts_lim[STS_LHI-3] <= above(ltemp, lhigh);
      sts_lim[STS_LLO-3] <= below(ltemp, llow);
      sts_lim[STS_RHI-3] <= above(rtemp, rhigh);
      sts_lim[STS_RLO-3] <= below(rtemp, rlow);
      o_alert_oe <= cond | (o_alert_oe & ~ara_done);
    end
  end

  assign o_sda_out   = 1'b0;
  assign o_alert_out = 1'b0;
  assign o_standby   = cfg[CFG_STBY];
endmodule : tm_monitor
`default_nettype wire

// ### hdl/tm_pkg.sv
// Constants shared by the temperature monitor design
package tm_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned MCLK_HZ      = 25_000_000;
  localparam int unsigned CONV_GAP_US  = 1000;
  localparam int unsigned CONV_GAP_CYC = CONV_GAP_US * (MCLK_HZ / 1_000_000);
  // ----------------------------------------------------------------
  // Register addresses (same for read and write)
  // ----------------------------------------------------------------
  localparam logic [7:0] A_LOCAL   = 8'h00;
  localparam logic [7:0] A_REMOTE  = 8'h01;
  localparam logic [7:0] A_STATUS  = 8'h02;
  localparam logic [7:0] A_CONFIG  = 8'h03;
  localparam logic [7:0] A_LHIGH   = 8'h05;
  localparam logic [7:0] A_LLOW    = 8'h06;
  localparam logic [7:0] A_RHIGH   = 8'h07;
  localparam logic [7:0] A_RLOW    = 8'h08;
  localparam logic [7:0] A_ONESHOT = 8'h0f;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_STBY  = 6;
  localparam int STS_LHI   = 6;
  localparam int STS_LLO   = 5;
  localparam int STS_RHI   = 4;
  localparam int STS_RLO   = 3;
  localparam int STS_OPEN  = 2;
  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_HIGH   = 8'h7f;
  localparam logic [7:0] RST_LOW    = 8'hc9;
  localparam logic [7:0] RST_TEMP   = 8'h00;
  localparam logic [7:0] SHORT_CODE = 8'h80;
  localparam logic [6:0] ARA_ADDR   = 7'h0c;
  localparam logic [6:0] DEV_DFLT   = 7'h4c;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [3:0] LAST_BIT   = 4'h7;
endpackage : tm_pkg

// ### hdl/tm_sync.sv
// Two-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module tm_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_reset_n,
  input  wire logic         i_ce,
  // Levels
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta;

  generate
    if (W < 1) begin : g_bad
      $error("tm_sync width must be at least one");
    end
  endgenerate

  // Idle level high, as for pulled-up lines
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta   <= '1;
      o_sync <= '1;
    end else if (i_ce) begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule : tm_sync
`default_nettype wire

// ### dv/tm_monitor_checker.sv
// Port assertions for the temperature monitor
`timescale 1ns/1ps
`default_nettype none
module tm_monitor_checker (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Watched ports
  input wire logic i_conv_done,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_alert_out,
  input wire logic o_alert_oe,
  input wire logic o_adc_en,
  input wire logic o_conv_start,
  input wire logic o_conv_chan,
  input wire logic o_standby
);
  logic [9:0] idle_cnt;
  // Cycles since the data line was last pulled by the block
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) idle_cnt <= 10'h3ff;
    else if (o_sda_oe) idle_cnt <= 10'h000;
    else if (idle_cnt != 10'h3ff) idle_cnt <= idle_cnt + 10'h001;
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  a_open_drain_low: assert property (
    !o_sda_out && !o_alert_out) else $error("open drain pin driven high");
  a_start_pulse: assert property (
    o_conv_start |=> !o_conv_start) else $error("start longer than a cycle");
  a_chan_hold: assert property (
    o_conv_start |=> $stable(o_conv_chan) [*2])
    else $error("channel changed during conversion");
  a_remote_follows: assert property (
    i_conv_done && !o_conv_chan && !o_standby |->
    ##2 (o_conv_start && o_conv_chan)) else $error("remote start missing");
  a_standby_inhibit: assert property (
    $rose(o_standby) |=> !o_adc_en) else $error("converter on in standby");
  a_run_adc_on: assert property (
    !o_standby [*3] |-> o_adc_en) else $error("converter off while running");
  a_alert_release: assert property (
    $fell(o_alert_oe) |-> idle_cnt < 10'h190)
    else $error("alert released without alert response");
  a_reset_quiet: assert property (disable iff (1'b0)
    !i_reset_n |-> !o_sda_oe && !o_alert_oe && !o_conv_start)
    else $error("outputs active in reset");
endmodule : tm_monitor_checker
bind tm_monitor tm_monitor_checker u_chk (.i_mclk(i_mclk),
  .i_reset_n(i_reset_n), .i_conv_done(i_conv_done), .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe), .o_alert_out(o_alert_out), .o_alert_oe(o_alert_oe),
  .o_adc_en(o_adc_en), .o_conv_start(o_conv_start),
  .o_conv_chan(o_conv_chan), .o_standby(o_standby));
`default_nettype wire

// ### dv/tm_host.sv
// Serial management bus host model
`timescale 1ns/1ps
`default_nettype none
module tm_host
  import tm_pkg::*;
(
  // Clock
  input  wire logic i_mclk,
  // Bus lines, high enable pulls low
  input  wire logic i_sda,
  output logic      o_scl_oe,
  output logic      o_sda_oe
);
  localparam int Q = 8;
  logic [7:0] rd_byte;
  logic       nak;
  int         ack_err = 0;
  initial begin
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
  end
  task automatic q(input int n);
    repeat (n) @(negedge i_mclk);
  endtask : q
  task automatic bit_io(input logic b, output logic r);
    o_sda_oe = ~b;
    q(Q);
    o_scl_oe = 1'b0;
    q(Q);
    r = i_sda;
    q(Q);
    o_scl_oe = 1'b1;
    q(Q);
  endtask : bit_io
  task automatic byte_io(input logic [7:0] d, input logic ack_b);
    for (int i = 7; i >= 0; i--) bit_io(d[i], rd_byte[i]);
    bit_io(ack_b, nak);
  endtask : byte_io
  task automatic addr(input logic [7:0] b);
    o_sda_oe = 1'b0;
    o_scl_oe = 1'b0;
    q(Q);
    o_sda_oe = 1'b1;
    q(Q);
    o_scl_oe = 1'b1;
    q(Q);
    byte_io(b, 1'b1);
    if (nak) ack_err++;
  endtask : addr
  task automatic stop;
    o_sda_oe = 1'b1;
    q(Q);
    o_scl_oe = 1'b0;
    q(Q);
    o_sda_oe = 1'b0;
    q(Q);
  endtask : stop
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic has_d);
    addr({DEV_DFLT, 1'b0});
    byte_io(a, 1'b1);
    if (has_d) byte_io(d, 1'b1);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    wr(a, 8'h00, 1'b0);
    addr({DEV_DFLT, 1'b1});
    byte_io(8'hff, 1'b1);
    v = rd_byte;
    stop();
  endtask : rd
  task automatic ara(output logic [7:0] v);
    addr({ARA_ADDR, 1'b1});
    byte_io(8'hff, 1'b1);
    v = rd_byte;
    stop();
  endtask : ara
endmodule : tm_host
`default_nettype wire

// ### dv/temp_monitor_standby_fault_tb.sv
// Self-checking bench for the temperature monitor
`timescale 1ns/1ps
`default_nettype none
module temp_monitor_standby_fault_tb;
  import tm_pkg::*;
  typedef struct packed {
    logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] e;
  } tm_row_t;
  localparam tm_row_t [9:0] ROWS = '{
    '{1'b0, A_CONFIG, 8'h00, RST_CONFIG}, '{1'b0, A_LHIGH, 8'h00, RST_HIGH},
    '{1'b0, A_LLOW, 8'h00, RST_LOW}, '{1'b0, A_RHIGH, 8'h00, RST_HIGH},
    '{1'b0, A_RLOW, 8'h00, RST_LOW}, '{1'b0, A_LOCAL, 8'h00, 8'h19},
    '{1'b0, A_REMOTE, 8'h00, 8'h20}, '{1'b0, A_STATUS, 8'h00, 8'h00},
    '{1'b1, 8'h04, 8'h55, 8'h00}, '{1'b1, A_LHIGH, 8'h60, 8'h60}};
  logic       i_mclk = 1'b0, i_reset_n = 1'b1, i_conv_done = 1'b0;
  logic       i_conv_under = 1'b0, i_open_fault = 1'b0, rem_under = 1'b0;
  logic [7:0] i_conv_data = 8'h00, loc_v = 8'h19, v;
  int         cnv_cnt = 0, n_start = 0, bad_count = 0, check_count = 0;
  wire logic  sda, scl, h_scl_oe, h_sda_oe, o_sda_oe, o_alert_oe;
  wire logic  o_adc_en, o_conv_start, o_conv_chan, o_standby;
  assign sda = ~(h_sda_oe | o_sda_oe);
  assign scl = ~h_scl_oe;
  always #20 i_mclk = ~i_mclk;
  tm_monitor #(.GAP_CYCLES(20)) DUT (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_ce(1'b1), .i_scl(scl), .i_sda(sda), .o_sda_out(), .o_sda_oe(o_sda_oe),
    .o_alert_out(), .o_alert_oe(o_alert_oe), .o_adc_en(o_adc_en),
    .o_conv_start(o_conv_start), .o_conv_chan(o_conv_chan),
    .i_conv_done(i_conv_done), .i_conv_data(i_conv_data),
    .i_conv_under(i_conv_under), .i_open_fault(i_open_fault),
    .o_standby(o_standby));
  tm_host host (.i_mclk(i_mclk), .i_sda(sda), .o_scl_oe(h_scl_oe),
    .o_sda_oe(h_sda_oe));
  // ----------------------------------------------------------------
  // Converter model, answers five cycles after each start
  // ----------------------------------------------------------------
  always @(negedge i_mclk) begin
    i_conv_done <= 1'b0;
    if (o_conv_start) n_start <= n_start + 1;
    if (!i_reset_n) cnv_cnt <= 0;
    else if (o_conv_start) cnv_cnt <= 5;
    else if (cnv_cnt != 0) cnv_cnt <= cnv_cnt - 1;
    if (cnv_cnt == 1 && i_reset_n) begin
      i_conv_done  <= 1'b1;
      i_conv_under <= o_conv_chan & rem_under;
      i_conv_data  <= o_conv_chan ? (rem_under ? 8'h00 : 8'h20) : loc_v;
    end
  end
  // ----------------------------------------------------------------
  // Checks and verdict
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      bad_count++;
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, v);
    chk(v, e);
  endtask : rdchk
  task automatic shot(input int n);
    host.wr(A_ONESHOT, 8'h5a, 1'b1);
    host.q(n);
  endtask : shot
  task automatic finish_test;
    if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    #3600000;
    bad_count++;
    finish_test();
  end
  initial begin
    int s0;
    // Reset edge after time zero so every flop sees it
    #1 i_reset_n = 1'b0;
    repeat (2) @(negedge i_mclk);
    i_reset_n = 1'b1;
    for (int i = 9; i >= 0; i--) begin
      if (ROWS[i].wr) host.wr(ROWS[i].a, ROWS[i].d, 1'b1);
      rdchk(ROWS[i].a, ROWS[i].e);
    end
    host.wr(A_CONFIG, 8'h40, 1'b1);
    chk({7'h00, o_standby}, 8'h01);
    loc_v = 8'h2a;
    rem_under = 1'b1;
    s0 = n_start;
    host.q(300);
    chk(8'(n_start - s0), 8'h00);
    chk({7'h00, o_adc_en}, 8'h00);
    rdchk(A_LOCAL, 8'h19);
    s0 = n_start;
    shot(300);
    chk(8'(n_start - s0), 8'h02);
    chk({7'h00, o_standby}, 8'h01);
    chk({7'h00, o_adc_en}, 8'h00);
    rdchk(A_LOCAL, 8'h2a);
    rdchk(A_REMOTE, SHORT_CODE);
    rdchk(A_STATUS, 8'h08);
    chk({7'h00, o_alert_oe}, 8'h01);
    host.ara(v);
    chk(v, {DEV_DFLT, 1'b0});
    chk({7'h00, o_alert_oe}, 8'h01);
    host.wr(A_RLOW, 8'h80, 1'b1);
    host.ara(v);
    chk({7'h00, o_alert_oe}, 8'h00);
    rdchk(A_STATUS, 8'h00);
    i_open_fault = 1'b1;
    shot(300);
    rdchk(A_STATUS, 8'h04);
    chk({7'h00, o_alert_oe}, 8'h01);
    i_open_fault = 1'b0;
    shot(300);
    rdchk(A_STATUS, 8'h00);
    host.ara(v);
    chk({7'h00, o_alert_oe}, 8'h00);
    host.wr(A_CONFIG, 8'h00, 1'b1);
    loc_v = 8'h31;
    s0 = n_start;
    shot(100);
    chk({7'h00, o_adc_en}, 8'h01);
    chk({7'h00, (n_start - s0) > 16}, 8'h01);
    rdchk(A_LOCAL, 8'h31);
    i_open_fault = 1'b1;
    host.q(300);
    chk({7'h00, o_alert_oe}, 8'h01);
    i_reset_n = 1'b0;
    host.q(2);
    chk({6'h00, o_alert_oe, o_standby}, 8'h00);
    i_reset_n = 1'b1;
    i_open_fault = 1'b0;
    rdchk(A_RLOW, RST_LOW);
    chk(8'(host.ack_err), 8'h00);
    finish_test();
  end
endmodule : temp_monitor_standby_fault_tb
`default_nettype wire
